/* File: pkg/brsq_pkg.sv */
`default_nettype none
package brsq_pkg;
	// system clock and the processor bus phase reference
	localparam int unsigned CLK_HZ        = 40000000;
	localparam int unsigned PHASE_CLK_HZ  = 1987200;
	// phase clock divider: 40 MHz / 1.9872 MHz, rounded down to whole cycles
	localparam int unsigned PHASE_DIV     = CLK_HZ / PHASE_CLK_HZ;
	// board reset stretch and diagnostic hold tail, in ms
	localparam int unsigned STRETCH_MS    = 600;
	localparam int unsigned HOLD_MS       = 300;
	// counts in phase clock cycles
	localparam int unsigned STRETCH_TICKS = (PHASE_CLK_HZ / 1000) * STRETCH_MS;
	localparam int unsigned HOLD_TICKS    = (PHASE_CLK_HZ / 1000) * HOLD_MS;
	// watchdog reset pulse width, phase clock cycles
	localparam int unsigned WDOG_PULSE    = 2;
	// watchdog timeout default, phase clock cycles (arbitrary plain default)
	localparam int unsigned WDOG_TICKS    = 65536;
	localparam int unsigned CNT_W         = 24;
	// board reset states, gray coded along stretch -> run
	typedef enum logic [1:0] {
		BRSQ_STRETCH = 2'b00,
		BRSQ_RUN     = 2'b01,
		BRSQ_WDPULSE = 2'b11
	} brsq_state_t;
endpackage : brsq_pkg
`default_nettype wire

/* File: core/brsq_top.sv */
// Functional notes
// - board reset held ~600 ms after supply good
// - low main supply restarts reset stretch
// - test switch press restarts reset stretch
// - logic undervoltage asserts board reset
// - watchdog resets when software stops servicing
// - watchdog timeout gives two-phase-cycle reset pulse
// - hold goes high when board reset low
// - hold stays high 300 ms after release
// - hold blocks keyup and status-bus writes
// - expansion reset is inverse of hold
// - processor output may also assert expansion reset
// - durations counted in 2 MHz phase cycles (40 MHz / 20)
`timescale 1ns/1ps
`default_nettype none
module brsq_top #(
	parameter int unsigned STRETCH_TICKS = brsq_pkg::STRETCH_TICKS,
	parameter int unsigned HOLD_TICKS    = brsq_pkg::HOLD_TICKS,
	parameter int unsigned WDOG_TICKS    = brsq_pkg::WDOG_TICKS,
	parameter int unsigned PHASE_DIV     = brsq_pkg::PHASE_DIV
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic logic_supply_good,
	input  wire logic main_supply_low,
	input  wire logic logic_undervolt,
	input  wire logic test_switch,
	input  wire logic wdog_service,
	input  wire logic cpu_exp_reset,
	input  wire logic keyup_req,
	input  wire logic status_bus_wr_req,
	output logic      board_reset_n,
	output logic      diag_hold,
	output logic      exp_reset_n,
	output logic      keyup_en,
	output logic      status_bus_wr_en,
	output logic      phase_tick
);
	localparam int unsigned CW = brsq_pkg::CNT_W;

	// saturating decrement used by all three timers
	function automatic logic [CW-1:0] dec_sat(input logic [CW-1:0] v);
		dec_sat = (v == '0) ? v : v - 1'b1;
	endfunction : dec_sat

	logic [7:0]    div_r, div_nxt;
	logic          tick_r, tick_nxt;
	brsq_pkg::brsq_state_t st_r, st_nxt;
	logic [CW-1:0] str_r, str_nxt;
	logic [CW-1:0] wd_r, wd_nxt;
	logic [CW-1:0] hold_r, hold_nxt;
	logic          brst_r, brst_nxt;
	logic          hold_q_r, hold_q_nxt;
	logic          exp_r, exp_nxt;
	logic          key_r, key_nxt;
	logic          wr_r, wr_nxt;
	logic          src;

	// any stretch source; supply not yet good counts as one
	assign src = !logic_supply_good || main_supply_low || test_switch;

	// phase clock enable from the system clock
	always_comb begin
		div_nxt  = div_r + 8'h01;
		tick_nxt = 1'b0;
		if (div_r == 8'(PHASE_DIV - 1)) begin
			div_nxt  = 8'h00;
			tick_nxt = 1'b1;
		end
	end

	// board reset sequencing: stretch, run, watchdog pulse
	always_comb begin
		st_nxt  = st_r;
		str_nxt = str_r;
		wd_nxt  = wd_r;
		case (st_r)
			brsq_pkg::BRSQ_STRETCH: begin
				wd_nxt = CW'(WDOG_TICKS);
				if (src) begin
					str_nxt = CW'(STRETCH_TICKS);
				end else if (tick_r) begin
					str_nxt = dec_sat(str_r);
					if (str_r <= 1) begin
						st_nxt = brsq_pkg::BRSQ_RUN;
					end
				end
			end
			brsq_pkg::BRSQ_RUN: begin
				if (src) begin
					st_nxt  = brsq_pkg::BRSQ_STRETCH;
					str_nxt = CW'(STRETCH_TICKS);
				end else if (wdog_service) begin
					wd_nxt = CW'(WDOG_TICKS);
				end else if (tick_r) begin
					wd_nxt = dec_sat(wd_r);
					if (wd_r <= 1) begin
						st_nxt  = brsq_pkg::BRSQ_WDPULSE;
						str_nxt = CW'(brsq_pkg::WDOG_PULSE);
					end
				end
			end
			brsq_pkg::BRSQ_WDPULSE: begin
				wd_nxt = CW'(WDOG_TICKS);
				if (src) begin
					st_nxt  = brsq_pkg::BRSQ_STRETCH;
					str_nxt = CW'(STRETCH_TICKS);
				end else if (tick_r) begin
					str_nxt = dec_sat(str_r);
					if (str_r <= 1) begin
						st_nxt = brsq_pkg::BRSQ_RUN;
					end
				end
			end
			default: begin
				st_nxt  = brsq_pkg::BRSQ_STRETCH;
				str_nxt = CW'(STRETCH_TICKS);
			end
		endcase
	end

	// outputs; undervoltage pulls reset low directly, like a passive pulldown
	always_comb begin
		brst_nxt = (st_nxt == brsq_pkg::BRSQ_RUN) && !logic_undervolt;
		hold_nxt = hold_r;
		hold_q_nxt = hold_q_r;
		if (!brst_r) begin
			hold_nxt   = CW'(HOLD_TICKS);
			hold_q_nxt = 1'b1;
		end else if (tick_r) begin
			hold_nxt = dec_sat(hold_r);
			if (hold_r <= 1) begin
				hold_q_nxt = 1'b0;
			end
		end
		if (!brst_nxt) begin
			hold_q_nxt = 1'b1;
		end
		// expansion reset follows hold; the processor can add to it
		exp_nxt = !(hold_q_nxt || cpu_exp_reset);
		key_nxt = keyup_req && !hold_q_nxt;
		wr_nxt  = status_bus_wr_req && !hold_q_nxt;
	end

	// registers; everything holds reset-safe values during rstn
	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_r    <= 8'h00;
			tick_r   <= 1'b0;
			st_r     <= brsq_pkg::BRSQ_STRETCH;
			str_r    <= CW'(STRETCH_TICKS);
			wd_r     <= CW'(WDOG_TICKS);
			hold_r   <= CW'(HOLD_TICKS);
			brst_r   <= 1'b0;
			hold_q_r <= 1'b1;
			exp_r    <= 1'b0;
			key_r    <= 1'b0;
			wr_r     <= 1'b0;
		end else begin
			div_r    <= div_nxt;
			tick_r   <= tick_nxt;
			st_r     <= st_nxt;
			str_r    <= str_nxt;
			wd_r     <= wd_nxt;
			hold_r   <= hold_nxt;
			brst_r   <= brst_nxt;
			hold_q_r <= hold_q_nxt;
			exp_r    <= exp_nxt;
			key_r    <= key_nxt;
			wr_r     <= wr_nxt;
		end
	end

	assign board_reset_n    = brst_r;
	assign diag_hold        = hold_q_r;
	assign exp_reset_n      = exp_r;
	assign keyup_en         = key_r;
	assign status_bus_wr_en = wr_r;
	assign phase_tick       = tick_r;

	// assertions
	property p_uv;
		@(posedge clk) disable iff (!rstn) logic_undervolt |=> !board_reset_n;
	endproperty
	a_uv: assert property (p_uv) else $error("undervolt did not reset");
	property p_src;
		@(posedge clk) disable iff (!rstn) src |=> !board_reset_n;
	endproperty
	a_src: assert property (p_src) else $error("source did not reset");
	property p_hold_hi;
		@(posedge clk) disable iff (!rstn) !board_reset_n |-> diag_hold;
	endproperty
	a_hold_hi: assert property (p_hold_hi) else $error("hold low in reset");
	property p_hold_tail;
		@(posedge clk) disable iff (!rstn) $rose(board_reset_n) |=> diag_hold;
	endproperty
	a_hold_tail: assert property (p_hold_tail) else $error("hold dropped early");
	property p_key;
		@(posedge clk) disable iff (!rstn) diag_hold |-> !keyup_en;
	endproperty
	a_key: assert property (p_key) else $error("keyup during hold");
	property p_wr;
		@(posedge clk) disable iff (!rstn) diag_hold |-> !status_bus_wr_en;
	endproperty
	a_wr: assert property (p_wr) else $error("bus write during hold");
	property p_exp;
		@(posedge clk) disable iff (!rstn) diag_hold |-> !exp_reset_n;
	endproperty
	a_exp: assert property (p_exp) else $error("expansion reset released");
	property p_cpu;
		@(posedge clk) disable iff (!rstn) cpu_exp_reset |=> !exp_reset_n;
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu expansion reset lost");
	sequence s_tick;
		tick_r ##1 !tick_r;
	endsequence
	property p_tick;
		@(posedge clk) disable iff (!rstn) tick_r |-> s_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("phase tick too long");
endmodule : brsq_top
`default_nettype wire

/* File: tb/brsq_exp_board.sv */
`timescale 1ns/1ps
`default_nettype none
// expansion board model: holds itself in reset while its reset line is low
module brsq_exp_board (
	input  wire logic clk,
	input  wire logic exp_reset_n,
	output logic      in_reset
);
	// registered, as a board's own reset synchroniser would be
	always_ff @(posedge clk) begin
		in_reset <= !exp_reset_n;
	end
endmodule : brsq_exp_board
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int PD = 2;
	localparam int ST = 10;
	localparam int HT = 5;
	localparam int WT = 20;
	logic      clk, rstn, good, mlow, uv, tsw, svc, cpu, key, wr;
	wire logic brn, hold, ern, key_en, wr_en, tick, in_rst;
	int        n_mismatch = 0;
	int        n_compared = 0;
	int        n;
	brsq_top #(.STRETCH_TICKS(ST), .HOLD_TICKS(HT), .WDOG_TICKS(WT), .PHASE_DIV(PD)) dut (
		.clk(clk), .rstn(rstn), .logic_supply_good(good), .main_supply_low(mlow),
		.logic_undervolt(uv), .test_switch(tsw), .wdog_service(svc), .cpu_exp_reset(cpu),
		.keyup_req(key), .status_bus_wr_req(wr), .board_reset_n(brn), .diag_hold(hold),
		.exp_reset_n(ern), .keyup_en(key_en), .status_bus_wr_en(wr_en), .phase_tick(tick));
	brsq_exp_board board (.clk(clk), .exp_reset_n(ern), .in_reset(in_rst));
	// 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic end_sim();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// sample just after the edge so its updates have landed
	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : step
	// cycles until board reset (sel=0) or hold (sel=1) releases; bounded
	task automatic wait_rel(input bit sel, output int c);
		c = 0;
		while ((sel ? hold : ~brn) !== 1'b0 && c < 200) begin
			step(1);
			c++;
		end
		if (c >= 200) begin
			n_mismatch++;
			end_sim();
		end
	endtask : wait_rel
	// hold tail after board release, then gated requests pass again
	task automatic t_tail();
		chk(in_rst, 1);
		chk(key_en, 0);
		chk(wr_en, 0);
		chk(ern, 0);
		wait_rel(1, n);
		chk(n >= HT*PD-PD && n <= HT*PD+PD+2, 1);
		step(2);
		chk(ern, 1);
		chk(in_rst, 0);
		chk({key_en, wr_en}, 2'h3);
	endtask : t_tail
	task automatic t_powerup();
		@(posedge clk) good <= 1'b1;
		step(2);
		chk({brn, hold}, 2'h1);
		wait_rel(0, n);
		chk(n >= ST*PD-PD && n <= ST*PD+PD+2, 1);
		t_tail();
	endtask : t_powerup
	// drive one stretch source, retrigger it mid-stretch, time from last release
	task automatic t_source(input int s);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk) {tsw, mlow, good} <= {s == 2, s == 1, s != 0};
			step(2);
			chk(brn, 0);
			@(posedge clk) {tsw, mlow, good} <= 3'h1;
			step(8);
		end
		wait_rel(0, n);
		chk(n >= ST*PD-PD-8 && n <= ST*PD+PD-6, 1);
		t_tail();
	endtask : t_source
	task automatic t_undervolt();
		@(posedge clk) uv <= 1'b1;
		step(3);
		chk({brn, hold}, 2'h1);
		@(posedge clk) uv <= 1'b0;
		wait_rel(0, n);
		chk(n < 4, 1);
		t_tail();
	endtask : t_undervolt
	task automatic t_wdog();
		@(posedge clk) svc <= 1'b0;
		n = 0;
		while (brn !== 1'b0 && n < 200) begin
			step(1);
			n++;
		end
		chk(n >= WT*PD-PD && n <= WT*PD+PD, 1);
		if (n >= 200) end_sim();
		@(posedge clk) svc <= 1'b1;
		wait_rel(0, n);
		chk(n >= 2*PD-2 && n <= 2*PD+1, 1);
		t_tail();
	endtask : t_wdog
	task automatic t_cpu_tick();
		// requests dropped too, so the gates must follow the request as well as hold
		@(posedge clk) {cpu, key, wr} <= 3'h4;
		step(2);
		chk({ern, hold}, 2'h0);
		chk(in_rst, 1);
		chk({key_en, wr_en}, 2'h0);
		@(posedge clk) {cpu, key, wr} <= 3'h3;
		step(2);
		chk(ern, 1);
		chk({key_en, wr_en}, 2'h3);
		n = 0;
		repeat (10*PD) begin
			step(1);
			n += tick;
		end
		chk(n, 10);
	endtask : t_cpu_tick
	// mid-run reset: outputs take reset values, then a fresh stretch and tail
	task automatic t_reset();
		@(posedge clk) rstn <= 1'b0;
		step(2);
		chk({brn, hold, ern, key_en, wr_en, tick}, 6'h10);
		@(posedge clk) rstn <= 1'b1;
		wait_rel(0, n);
		chk(n >= ST*PD-PD && n <= ST*PD+PD+2, 1);
		t_tail();
	endtask : t_reset
	initial begin
		{rstn, good, mlow, uv, tsw, cpu} = 6'h0;
		{svc, key, wr} = 3'h7;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_powerup();
		for (int s = 0; s < 3; s++) t_source(s);
		t_undervolt();
		t_wdog();
		t_cpu_tick();
		t_reset();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
